// ---- logic/ccd_pkg.sv ----
// Constants, opcodes, state enumeration and state record of the core datapath.
// Assumes a single system clock; the private opcode map is local to this core.
package ccd_pkg;

  // ----------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------
  localparam int REG_NUM = 32;
  localparam logic [15:0] DATA_IO_BASE = 16'h0020;
  localparam logic [15:0] DATA_EXT_BASE = 16'h0060;
  localparam logic [5:0] STATUS_IO_ADDR = 6'h3F;
  localparam logic [15:0] STATUS_DATA_ADDR = 16'h005F;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] FSW_LO_REG = 5'h00;
  localparam logic [4:0] FSW_HI_REG = 5'h01;
  localparam logic [15:0] VEC_WORDS = 16'h0002;
  localparam int IRQ_ID_W = 5;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int FL_I = 7;
  localparam int FL_T = 6;
  localparam int FL_H = 5;
  localparam int FL_S = 4;
  localparam int FL_V = 3;
  localparam int FL_N = 2;
  localparam int FL_Z = 1;
  localparam int FL_C = 0;

  // ----------------------------------------------------------------
  // Opcodes in word bits 15:12
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_ALU = 4'h1;
  localparam logic [3:0] OP_SUBI = 4'h2;
  localparam logic [3:0] OP_LDI = 4'h3;
  localparam logic [3:0] OP_BIT = 4'h4;
  localparam logic [3:0] OP_IN = 4'h5;
  localparam logic [3:0] OP_OUT = 4'h6;
  localparam logic [3:0] OP_POINTER_READ = 4'h7;
  localparam logic [3:0] OP_POINTER_WRITE = 4'h8;
  localparam logic [3:0] OP_DIRECT_DATA_READ = 4'h9;
  localparam logic [3:0] OP_DIRECT_DATA_WRITE = 4'hA;
  localparam logic [3:0] OP_CALL = 4'hB;
  localparam logic [3:0] OP_RETURN = 4'hC;
  localparam logic [3:0] OP_FLASH_SELF_WRITE = 4'hD;
  localparam logic [3:0] OP_TABLE_READ = 4'hE;
  localparam logic [1:0] SUB_ADD = 2'h0;
  localparam logic [1:0] SUB_SUB = 2'h1;
  localparam logic [1:0] SUB_AND = 2'h2;
  localparam logic [1:0] SUB_COPY_BIT_TO_FLAG = 2'h0;
  localparam logic [1:0] SUB_COPY_FLAG_TO_BIT = 2'h1;
  localparam logic [1:0] SUB_SET_IRQ_ENABLE = 2'h2;

  typedef enum logic [3:0] {
    PH_RUN, PH_WORD2, PH_PUSH, PH_POP1, PH_POP2, PH_POP3, PH_LOAD1, PH_LOAD2, PH_TBL1, PH_TBL2
  } ccd_state_t;

  typedef struct packed {
    ccd_state_t ph;
    logic [REG_NUM-1:0][7:0] rf;
    logic [7:0] sr;
    logic [15:0] fa;
    logic [15:0] pa;
    logic fv;
    logic [15:0] ir;
    logic [15:0] ret;
    logic [15:0] tgt;
    logic [15:0] sp;
    logic [4:0] dst;
    logic return_from_irq_op;
    logic [15:0] dadr;
    logic [7:0] dwd;
    logic dwe;
    logic dre;
    logic fwr;
    logic [15:0] fadr;
    logic [15:0] fdat;
    logic ack;
    logic [IRQ_ID_W-1:0] aid;
  } ccd_core_t;

endpackage : ccd_pkg

// ---- logic/ccd_core.sv ----
// 8-bit core datapath: fetch overlap, register file, ALU, status flags, interrupts.
// Assumes program memory and data memory answer one clock after the address.
//
// Function
// - Fetch next word while current one executes.
// - Thirty-two 8-bit working registers, single cycle.
// - Read, compute, write back in one cycle.
// - Three register pairs form pointers; one reads flash.
// - Instructions are one or two words.
// - Flash self-write only from boot section.
// - Push return address on call and interrupt.
// - Lowest vector wins among pending interrupts.
// - I/O space mirrored at data 0x20-0x5F.
// - I/O ops use 0x00-0x3F, data ops add 0x20.
// - Extended I/O only through data-space ops.
// - ALU operations update status flags.
// - Status not saved or restored on interrupts.
// - Status at I/O 0x3F, reset zero, read/write.
// - Global enable bit 7 gates every interrupt.
// - Enable cleared on entry, set on return from interrupt.
// - Bit 6 stores one copied register bit.
// - Bit 5 holds half carry.
// - Sign equals negative xor overflow.
// - Bits 3-0 are overflow, negative, zero, carry.
`timescale 1ns/1ps
module ccd_core #(
  parameter int N_IRQ = 8,
  parameter logic [15:0] BOOT_START = 16'hF000,
  parameter logic [15:0] STACK_TOP = 16'h10FF
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  output logic [15:0] prog_addr_o,
  input wire logic [15:0] prog_data_i,
  output logic [15:0] data_addr_o,
  output logic [7:0] data_wdata_o,
  output logic data_we_o,
  output logic data_re_o,
  input wire logic [7:0] data_rdata_i,
  output logic flash_wr_o,
  output logic [15:0] flash_addr_o,
  output logic [15:0] flash_data_o,
  input wire logic [N_IRQ-1:0] irq_req_i,
  output logic irq_ack_o,
  output logic [ccd_pkg::IRQ_ID_W-1:0] irq_id_o,
  output logic [7:0] status_o
);

  ccd_pkg::ccd_core_t s_q;
  ccd_pkg::ccd_core_t s_d;
  logic [15:0] w;
  logic [3:0] op;
  logic [1:0] sub;
  logic [4:0] rd;
  logic [4:0] rs;
  logic [4:0] rdh;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] res;
  logic [8:0] wide;
  logic [4:0] half;
  logic alu_go;
  logic arith;
  logic is_sub;
  logic [4:0] plo;
  logic [15:0] ptr;
  logic irq_hit;
  logic [ccd_pkg::IRQ_ID_W-1:0] irq_id;
  logic acc_go;
  logic acc_wr;
  logic [15:0] acc_addr;
  logic [4:0] acc_reg;

  // ----------------------------------------------------------------
  // Decode and next state
  // ----------------------------------------------------------------

  // One process computes the whole next state; the ALU result and flags are formed in the same cycle.
  always_comb begin
    s_d = s_q;
    s_d.dwe = 1'b0;
    s_d.dre = 1'b0;
    s_d.fwr = 1'b0;
    s_d.ack = 1'b0;
    w = (s_q.ph == ccd_pkg::PH_WORD2) ? s_q.ir : prog_data_i;
    op = w[15:12];
    sub = w[11:10];
    rd = w[9:5];
    rs = w[4:0];
    rdh = {1'b1, w[11:8]};
    alu_go = 1'b0;
    arith = 1'b0;
    is_sub = 1'b0;
    a = s_q.rf[rd];
    b = s_q.rf[rs];
    res = 8'h00;
    acc_go = 1'b0;
    acc_wr = 1'b0;
    acc_addr = 16'h0000;
    acc_reg = rd;
    plo = ccd_pkg::PTR_X_LO + {2'b00, sub, 1'b0};
    ptr = {s_q.rf[plo + 5'h01], s_q.rf[plo]};
    // Lowest index is scanned last so it wins.
    irq_hit = 1'b0;
    irq_id = '0;
    for (int i = N_IRQ - 1; i >= 0; i--) begin
      if (irq_req_i[i]) begin
        irq_hit = 1'b1;
        irq_id = i[ccd_pkg::IRQ_ID_W-1:0];
      end
    end
    if (op == ccd_pkg::OP_SUBI || op == ccd_pkg::OP_LDI) begin
      a = s_q.rf[rdh];
      b = w[7:0];
    end
    wide = 9'h000;
    half = 5'h00;
    case (s_q.ph)
      ccd_pkg::PH_RUN: begin
        // Overlap: the next word is addressed while the present one executes.
        s_d.pa = s_q.fa;
        s_d.fa = s_q.fa + 16'h0001;
        s_d.fv = 1'b1;
        s_d.ret = s_q.pa + 16'h0001;
        if (s_q.fv && s_q.sr[ccd_pkg::FL_I] && irq_hit) begin
          // Interrupt replaces the fetched word; only the enable bit of the status register is cleared.
          s_d.sr[ccd_pkg::FL_I] = 1'b0;
          s_d.ack = 1'b1;
          s_d.aid = irq_id;
          s_d.ret = s_q.pa;
          s_d.tgt = 16'(irq_id) * ccd_pkg::VEC_WORDS;
          s_d.dadr = s_q.sp;
          s_d.dwd = s_q.pa[7:0];
          s_d.dwe = 1'b1;
          s_d.sp = s_q.sp - 16'h0001;
          s_d.fv = 1'b0;
          s_d.ph = ccd_pkg::PH_PUSH;
        end else if (s_q.fv) begin
          case (op)
            ccd_pkg::OP_ALU, ccd_pkg::OP_SUBI, ccd_pkg::OP_LDI: begin
              alu_go = (op != ccd_pkg::OP_LDI);
              arith = (op == ccd_pkg::OP_SUBI) || (sub == ccd_pkg::SUB_ADD) || (sub == ccd_pkg::SUB_SUB);
              is_sub = (op == ccd_pkg::OP_SUBI) || (op == ccd_pkg::OP_ALU && sub == ccd_pkg::SUB_SUB);
            end
            ccd_pkg::OP_BIT: begin
              case (sub)
                ccd_pkg::SUB_COPY_BIT_TO_FLAG: s_d.sr[ccd_pkg::FL_T] = s_q.rf[rd][rs[2:0]];
                ccd_pkg::SUB_COPY_FLAG_TO_BIT: s_d.rf[rd][rs[2:0]] = s_q.sr[ccd_pkg::FL_T];
                ccd_pkg::SUB_SET_IRQ_ENABLE: s_d.sr[ccd_pkg::FL_I] = 1'b1;
                default: s_d.sr[ccd_pkg::FL_I] = 1'b0;
              endcase
            end
            ccd_pkg::OP_IN, ccd_pkg::OP_OUT: begin
              // Six address bits cannot reach past 0x3F, so extended I/O is out of range here.
              acc_go = 1'b1;
              acc_wr = (op == ccd_pkg::OP_OUT);
              acc_addr = {10'h000, sub, w[3:0]} + ccd_pkg::DATA_IO_BASE;
            end
            ccd_pkg::OP_POINTER_READ, ccd_pkg::OP_POINTER_WRITE: begin
              acc_go = 1'b1;
              acc_wr = (op == ccd_pkg::OP_POINTER_WRITE);
              acc_addr = ptr;
              acc_reg = rs;
            end
            ccd_pkg::OP_DIRECT_DATA_READ, ccd_pkg::OP_DIRECT_DATA_WRITE, ccd_pkg::OP_CALL: begin
              s_d.ir = prog_data_i;
              s_d.ph = ccd_pkg::PH_WORD2;
            end
            ccd_pkg::OP_RETURN: begin
              s_d.return_from_irq_op = sub[0];
              s_d.dadr = s_q.sp + 16'h0001;
              s_d.dre = 1'b1;
              s_d.fv = 1'b0;
              s_d.ph = ccd_pkg::PH_POP1;
            end
            ccd_pkg::OP_FLASH_SELF_WRITE: begin
              // Writes issued from the application section are dropped.
              s_d.fwr = (s_q.pa >= BOOT_START);
              s_d.fadr = {s_q.rf[ccd_pkg::PTR_X_LO + 5'h05], s_q.rf[ccd_pkg::PTR_X_LO + 5'h04]};
              s_d.fdat = {s_q.rf[ccd_pkg::FSW_HI_REG], s_q.rf[ccd_pkg::FSW_LO_REG]};
            end
            ccd_pkg::OP_TABLE_READ: begin
              s_d.tgt = {s_q.rf[ccd_pkg::PTR_X_LO + 5'h05], s_q.rf[ccd_pkg::PTR_X_LO + 5'h04]};
              s_d.fa = {1'b0, s_d.tgt[15:1]};
              s_d.dst = rd;
              s_d.fv = 1'b0;
              s_d.ph = ccd_pkg::PH_TBL1;
            end
            default: begin
            end
          endcase
        end
      end
      ccd_pkg::PH_WORD2: begin
        // Second word carries the address; pa now holds its location.
        s_d.pa = s_q.fa;
        s_d.fa = s_q.fa + 16'h0001;
        s_d.ret = s_q.pa + 16'h0001;
        s_d.ph = ccd_pkg::PH_RUN;
        if (op == ccd_pkg::OP_CALL) begin
          s_d.tgt = prog_data_i;
          s_d.dadr = s_q.sp;
          s_d.dwd = s_d.ret[7:0];
          s_d.dwe = 1'b1;
          s_d.sp = s_q.sp - 16'h0001;
          s_d.fv = 1'b0;
          s_d.ph = ccd_pkg::PH_PUSH;
        end else begin
          acc_go = 1'b1;
          acc_wr = (op == ccd_pkg::OP_DIRECT_DATA_WRITE);
          acc_addr = prog_data_i;
        end
      end
      ccd_pkg::PH_PUSH: begin
        s_d.dadr = s_q.sp;
        s_d.dwd = s_q.ret[15:8];
        s_d.dwe = 1'b1;
        s_d.sp = s_q.sp - 16'h0001;
        s_d.fa = s_q.tgt;
        s_d.ph = ccd_pkg::PH_RUN;
      end
      ccd_pkg::PH_POP1: begin
        s_d.dadr = s_q.sp + 16'h0002;
        s_d.dre = 1'b1;
        s_d.sp = s_q.sp + 16'h0002;
        s_d.ph = ccd_pkg::PH_POP2;
      end
      ccd_pkg::PH_POP2: begin
        s_d.tgt[15:8] = data_rdata_i;
        s_d.ph = ccd_pkg::PH_POP3;
      end
      ccd_pkg::PH_POP3: begin
        s_d.fa = {s_q.tgt[15:8], data_rdata_i};
        s_d.sr[ccd_pkg::FL_I] = s_q.sr[ccd_pkg::FL_I] | s_q.return_from_irq_op;
        s_d.ph = ccd_pkg::PH_RUN;
      end
      ccd_pkg::PH_LOAD1: s_d.ph = ccd_pkg::PH_LOAD2;
      ccd_pkg::PH_LOAD2: begin
        s_d.rf[s_q.dst] = data_rdata_i;
        s_d.fa = s_q.ret;
        s_d.ph = ccd_pkg::PH_RUN;
      end
      ccd_pkg::PH_TBL1: s_d.ph = ccd_pkg::PH_TBL2;
      ccd_pkg::PH_TBL2: begin
        s_d.rf[s_q.dst] = s_q.tgt[0] ? prog_data_i[15:8] : prog_data_i[7:0];
        s_d.fa = s_q.ret;
        s_d.ph = ccd_pkg::PH_RUN;
      end
      default: s_d.ph = ccd_pkg::PH_RUN;
    endcase
    // Single-cycle ALU with per-operation flag rules.
    wide = is_sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    half = is_sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]}) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
    if (op == ccd_pkg::OP_LDI) begin
      res = b;
    end else if (arith) begin
      res = wide[7:0];
    end else if (sub == ccd_pkg::SUB_AND) begin
      res = a & b;
    end else begin
      res = a ^ b;
    end
    if (s_q.ph == ccd_pkg::PH_RUN && s_q.fv && !(s_q.sr[ccd_pkg::FL_I] && irq_hit)) begin
      if (op == ccd_pkg::OP_LDI || alu_go) begin
        s_d.rf[(op == ccd_pkg::OP_ALU) ? rd : rdh] = res;
      end
      if (alu_go) begin
        if (arith) begin
          s_d.sr[ccd_pkg::FL_H] = half[4];
          s_d.sr[ccd_pkg::FL_C] = wide[8];
          s_d.sr[ccd_pkg::FL_V] = (is_sub ? (a[7] != b[7]) : (a[7] == b[7])) && (res[7] != a[7]);
        end else begin
          s_d.sr[ccd_pkg::FL_V] = 1'b0;
        end
        s_d.sr[ccd_pkg::FL_N] = res[7];
        s_d.sr[ccd_pkg::FL_Z] = (res == 8'h00);
        s_d.sr[ccd_pkg::FL_S] = res[7] ^ s_d.sr[ccd_pkg::FL_V];
      end
    end
    // Data-space access: register file, status register, or the external bus with a wait on reads.
    if (acc_go) begin
      if (acc_addr < ccd_pkg::DATA_IO_BASE) begin
        if (acc_wr) begin
          s_d.rf[acc_addr[4:0]] = s_q.rf[acc_reg];
        end else begin
          s_d.rf[acc_reg] = s_q.rf[acc_addr[4:0]];
        end
      end else if (acc_addr == ccd_pkg::STATUS_DATA_ADDR) begin
        if (acc_wr) begin
          s_d.sr = s_q.rf[acc_reg];
        end else begin
          s_d.rf[acc_reg] = s_q.sr;
        end
      end else begin
        s_d.dadr = acc_addr;
        s_d.dwd = s_q.rf[acc_reg];
        s_d.dwe = acc_wr;
        s_d.dre = !acc_wr;
        if (!acc_wr) begin
          s_d.dst = acc_reg;
          s_d.fv = 1'b0;
          s_d.ph = ccd_pkg::PH_LOAD1;
        end
      end
    end
    // A redirected fetch makes the next arriving word stale.
    if (s_d.ph != ccd_pkg::PH_RUN || s_d.fa != s_q.fa + 16'h0001) begin
      s_d.fv = (s_d.ph == ccd_pkg::PH_WORD2) && (s_q.ph == ccd_pkg::PH_RUN);
    end
    if (sys_rst_i) begin
      s_d = '0;
      s_d.ph = ccd_pkg::PH_RUN;
      s_d.sr = ccd_pkg::STATUS_RESET;
      s_d.sp = STACK_TOP;
    end
  end

  // All state updates here.
  always_ff @(posedge clk_sys_i) begin
    s_q <= s_d;
  end

  assign prog_addr_o = s_q.fa;
  assign data_addr_o = s_q.dadr;
  assign data_wdata_o = s_q.dwd;
  assign data_we_o = s_q.dwe;
  assign data_re_o = s_q.dre;
  assign flash_wr_o = s_q.fwr;
  assign flash_addr_o = s_q.fadr;
  assign flash_data_o = s_q.fdat;
  assign irq_ack_o = s_q.ack;
  assign irq_id_o = s_q.aid;
  assign status_o = s_q.sr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_push_lo;
    irq_ack_o && data_we_o;
  endsequence
  sequence s_push_hi;
    data_we_o && !irq_ack_o && data_addr_o == $past(data_addr_o) - 16'h0001;
  endsequence

  property p_push_ret; s_push_lo |=> s_push_hi; endproperty
  a_push_ret: assert property (p_push_ret) else $error("Return address not pushed as two bytes.");
  property p_gate; irq_ack_o |-> $past(status_o[ccd_pkg::FL_I]); endproperty
  a_gate: assert property (p_gate) else $error("Interrupt taken while globally disabled.");
  property p_clear_i; irq_ack_o |-> !status_o[ccd_pkg::FL_I]; endproperty
  a_clear_i: assert property (p_clear_i) else $error("Enable not cleared on interrupt entry.");
  property p_prio;
    irq_ack_o |-> ($past(irq_req_i) & ~({N_IRQ{1'b1}} << irq_id_o)) == '0 &&
      (($past(irq_req_i) >> irq_id_o) & N_IRQ'(1)) != '0;
  endproperty
  a_prio: assert property (p_prio) else $error("Interrupt priority order violated.");
  property p_sign; alu_go && !acc_go |=> status_o[ccd_pkg::FL_S] == (status_o[ccd_pkg::FL_N] ^ status_o[ccd_pkg::FL_V]); endproperty
  a_sign: assert property (p_sign) else $error("Sign flag differs from N xor V.");
  property p_zero; alu_go |=> status_o[ccd_pkg::FL_Z] == (s_q.rf[$past(op == ccd_pkg::OP_ALU ? rd : rdh)] == 8'h00); endproperty
  a_zero: assert property (p_zero) else $error("Zero flag does not match result.");
  property p_boot; flash_wr_o |-> $past(s_q.pa) >= BOOT_START; endproperty
  a_boot: assert property (p_boot) else $error("Flash self-write from application section.");
  property p_status_local; data_we_o || data_re_o |-> data_addr_o != ccd_pkg::STATUS_DATA_ADDR; endproperty
  a_status_local: assert property (p_status_local) else $error("Status register access leaked to bus.");
  property p_refill; s_q.ph == ccd_pkg::PH_RUN && !s_q.fv |=> s_q.fv; endproperty
  a_refill: assert property (p_refill) else $error("Fetch bubble longer than one cycle.");

endmodule : ccd_core

// ---- bench/cpu_core_status_datapath_tb.sv ----
// Self-checking testbench for the core datapath: program and data memories, scenario tasks, verdict.
// Assumes the core's private opcode map and memories that answer one clock after the address; opcode zero is a filler.
`timescale 1ns/1ps
module cpu_core_status_datapath_tb;
  // ----------------------------------------------------------------
  // Signals and memories
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] prog_addr_o, data_addr_o, flash_addr_o, flash_data_o;
  logic [15:0] prog_data_i = 16'h0000;
  logic [7:0] data_wdata_o, status_o;
  logic [7:0] data_rdata_i = 8'h00;
  logic [7:0] irq_req_i = 8'h00;
  logic data_we_o, data_re_o, flash_wr_o, irq_ack_o;
  logic [ccd_pkg::IRQ_ID_W-1:0] irq_id_o;
  logic [15:0] rom [0:65535];
  logic [7:0] dmem [0:65535];
  logic [15:0] fetch_q = 16'h0000;
  logic [15:0] rd_adr_q = 16'h0000;
  logic [15:0] flash_adr_q = 16'h0000;
  logic rd_v_q = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  int low_writes = 0;
  int flash_hits = 0;
  int ack_hits = 0;
  logic [15:0] pc = 16'h0000;

  // The clock toggles every half period of 2 ns.
  always #2 clk_sys_i = ~clk_sys_i;

  ccd_core DUT (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i),
    .data_addr_o(data_addr_o), .data_wdata_o(data_wdata_o), .data_we_o(data_we_o), .data_re_o(data_re_o),
    .data_rdata_i(data_rdata_i), .flash_wr_o(flash_wr_o), .flash_addr_o(flash_addr_o),
    .flash_data_o(flash_data_o), .irq_req_i(irq_req_i), .irq_ack_o(irq_ack_o), .irq_id_o(irq_id_o),
    .status_o(status_o)
  );

  // ----------------------------------------------------------------
  // Memory models and monitors
  // ----------------------------------------------------------------
  // Strobes are sampled on the rising edge, the same edge the core launches from.
  always @(posedge clk_sys_i) begin
    fetch_q <= prog_addr_o;
    rd_v_q <= (data_re_o === 1'b1);
    rd_adr_q <= data_addr_o;
    if (data_we_o === 1'b1) begin
      dmem[data_addr_o] <= data_wdata_o;
      if (data_addr_o < 16'h0060) low_writes <= low_writes + 1;
    end
    if (flash_wr_o === 1'b1) begin
      flash_hits <= flash_hits + 1;
      flash_adr_q <= flash_addr_o;
    end
    if (irq_ack_o === 1'b1) ack_hits <= ack_hits + 1;
  end

  // Answers land at the falling edge; an idle read bus flips so a stale byte never looks valid.
  always @(negedge clk_sys_i) begin
    prog_data_i <= rom[fetch_q];
    data_rdata_i <= rd_v_q ? dmem[rd_adr_q] : ~data_rdata_i;
  end

  // ----------------------------------------------------------------
  // Encoders and shared tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] ldi(input logic [4:0] d, input logic [7:0] k);
    return {ccd_pkg::OP_LDI, d[3:0], k};
  endfunction : ldi

  function automatic logic [15:0] alu(input logic [1:0] s, input logic [4:0] d, input logic [4:0] r);
    return {ccd_pkg::OP_ALU, s, d, r};
  endfunction : alu

  function automatic logic [15:0] outw(input logic [5:0] io, input logic [4:0] r);
    return {ccd_pkg::OP_OUT, io[5:4], r, 1'b0, io[3:0]};
  endfunction : outw

  function automatic logic [15:0] dwr(input logic [4:0] r);
    return {ccd_pkg::OP_DIRECT_DATA_WRITE, 2'b00, r, 5'h00};
  endfunction : dwr

  task automatic put(input logic [15:0] w);
    rom[pc] = w;
    pc = pc + 16'h0001;
  endtask : put

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Holds reset and wipes program memory so a new program can be loaded.
  task automatic begin_prog();
    @(negedge clk_sys_i);
    sys_rst_i = 1'b1;
    irq_req_i = 8'h00;
    foreach (rom[i]) rom[i] = 16'h0000;
    pc = 16'h0000;
    low_writes = 0;
    flash_hits = 0;
    ack_hits = 0;
  endtask : begin_prog

  task automatic go();
    repeat (2) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
  endtask : go

  task automatic run(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : run

  // Waits for an acknowledge (sel 1) or a status value (sel 0); a hang ends the run as a failure.
  task automatic wait_for(input bit sel, input logic [7:0] v);
    int n;
    n = 0;
    while (!(sel ? (irq_ack_o === 1'b1) : (status_o === v))) begin
      if (n == 200) begin
        fail_count++;
        $display("wrong value wait expected %h seen %h", v, status_o);
        end_sim();
      end
      n++;
      @(negedge clk_sys_i);
    end
  endtask : wait_for

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    begin_prog();
    run(1);
    chk("status in reset", 16'h0000, {8'h00, status_o});
    chk("strobes in reset", 16'h0000, {13'h0000, data_we_o, irq_ack_o, flash_wr_o});
    go();
    run(4);
    chk("fetch address", 16'h0004, prog_addr_o);
    $display("reset test done");
  endtask : t_reset

  // Back-to-back dependent operations: 0x7F + 0x01 sets H, V, N; bit 7 then copied into T.
  task automatic t_add();
    begin_prog();
    put(ldi(5'd16, 8'h7F)); put(ldi(5'd17, 8'h01)); put(alu(ccd_pkg::SUB_ADD, 5'd16, 5'd17));
    put(dwr(5'd16)); put(16'h0100);
    put({ccd_pkg::OP_BIT, ccd_pkg::SUB_COPY_BIT_TO_FLAG, 5'd16, 5'h07});
    put(ldi(5'd26, 8'h00)); put(ldi(5'd27, 8'h02)); put({ccd_pkg::OP_POINTER_WRITE, 2'b00, 5'd0, 5'd16});
    go();
    run(25);
    chk("sum byte", 16'h0080, {8'h00, dmem[16'h0100]});
    chk("pointer store", 16'h0080, {8'h00, dmem[16'h0200]});
    chk("add flags", 16'h006C, {8'h00, status_o});
    $display("add test done");
  endtask : t_add

  // 0x01 - 0x02 borrows from both nibbles: H, S, N and C set, V clear.
  task automatic t_sub();
    begin_prog();
    put(ldi(5'd18, 8'h01)); put(ldi(5'd19, 8'h02)); put(alu(ccd_pkg::SUB_SUB, 5'd18, 5'd19));
    put(dwr(5'd18)); put(16'h0101);
    go();
    run(20);
    chk("difference byte", 16'h00FF, {8'h00, dmem[16'h0101]});
    chk("sub flags", 16'h0035, {8'h00, status_o});
    $display("sub test done");
  endtask : t_sub

  // Status through the I/O form, then through data space; only the status address stays off the bus.
  task automatic t_map();
    begin_prog();
    put(ldi(5'd20, 8'h40)); put(outw(ccd_pkg::STATUS_IO_ADDR, 5'd20));
    go();
    run(10);
    chk("status by io write", 16'h0040, {8'h00, status_o});
    begin_prog();
    put(ldi(5'd21, 8'hAA)); put(dwr(5'd21)); put(16'h0060);
    put(ldi(5'd22, 8'h03)); put(dwr(5'd22)); put(16'h005F);
    put(dwr(5'd21)); put(16'h0030);
    go();
    run(25);
    chk("extended io byte", 16'h00AA, {8'h00, dmem[16'h0060]});
    chk("status by data write", 16'h0003, {8'h00, status_o});
    chk("mirrored bus writes", 16'h0001, 16'(low_writes));
    chk("mirrored io byte", 16'h00AA, {8'h00, dmem[16'h0030]});
    $display("map test done");
  endtask : t_map

  // A flash table lookup through the third pointer and an I/O read from the bus, each stored back out.
  task automatic t_load();
    begin_prog();
    dmem[16'h0030] = 8'h5C;
    rom[16'h0010] = 16'hC35A;
    put(ldi(5'd30, 8'h21)); put(ldi(5'd31, 8'h00));
    put({ccd_pkg::OP_TABLE_READ, 2'b00, 5'd20, 5'd0}); put(dwr(5'd20)); put(16'h0102);
    put({ccd_pkg::OP_IN, 2'b01, 5'd21, 5'd0}); put(dwr(5'd21)); put(16'h0103);
    go();
    run(30);
    chk("table byte", 16'h00C3, {8'h00, dmem[16'h0102]});
    chk("io read byte", 16'h005C, {8'h00, dmem[16'h0103]});
    $display("load test done");
  endtask : t_load

  // Self-write from the application area is ignored; the same opcode in the boot area fires.
  task automatic t_flash();
    begin_prog();
    put(ldi(5'd30, 8'h34)); put(ldi(5'd31, 8'h12)); put({ccd_pkg::OP_FLASH_SELF_WRITE, 12'h000});
    run(1);
    put({ccd_pkg::OP_CALL, 12'h000}); put(16'hF000);
    rom[16'hF000] = {ccd_pkg::OP_FLASH_SELF_WRITE, 12'h000};
    go();
    run(6);
    chk("application self write", 16'h0000, 16'(flash_hits));
    run(25);
    chk("boot self write", 16'h0001, 16'(flash_hits));
    chk("self write address", 16'h1234, flash_adr_q);
    $display("flash test done");
  endtask : t_flash

  // Two requests pend while the enable is clear; the lower index wins, each return re-enables.
  task automatic t_irq();
    begin_prog();
    irq_req_i = 8'h0A;
    put({ccd_pkg::OP_CALL, 12'h000}); put(16'h0020); put({ccd_pkg::OP_RETURN, 12'h400});
    pc = 16'h0006; put({ccd_pkg::OP_RETURN, 12'h400});
    pc = 16'h0020; put(ldi(5'd16, 8'h02)); put(outw(ccd_pkg::STATUS_IO_ADDR, 5'd16));
    put(ldi(5'd17, 8'h00)); put(ldi(5'd18, 8'h00)); put(ldi(5'd19, 8'h00));
    put({ccd_pkg::OP_BIT, ccd_pkg::SUB_SET_IRQ_ENABLE, 10'h000});
    go();
    wait_for(1'b0, 8'h02);
    run(2);
    chk("ack while disabled", 16'h0000, 16'(ack_hits));
    chk("call return low", 16'h0002, {8'h00, dmem[16'h10FF]});
    chk("call return high", 16'h0000, {8'h00, dmem[16'h10FE]});
    wait_for(1'b1, 8'h00);
    chk("first id", 16'h0001, 16'(irq_id_o));
    chk("status on entry", 16'h0002, {8'h00, status_o});
    chk("push address", 16'h10FD, data_addr_o);
    chk("push strobe", 16'h0001, {15'h0000, data_we_o});
    irq_req_i = 8'h08;
    run(1);
    chk("vector fetch", 16'h0002, prog_addr_o);
    wait_for(1'b1, 8'h00);
    chk("second id", 16'h0003, 16'(irq_id_o));
    irq_req_i = 8'h00;
    run(25);
    chk("status after return", 16'h0082, {8'h00, status_o});
    $display("interrupt test done");
  endtask : t_irq

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    t_reset();
    t_add();
    t_sub();
    t_map();
    t_flash();
    t_load();
    t_irq();
    end_sim();
  end
endmodule : cpu_core_status_datapath_tb
